// >>> logic/ulfs_map.vh
`ifndef ULFS_MAP_VH
`define ULFS_MAP_VH
// register word offsets (byte address = 4 * index)
`define ULFS_IDX_DATA      3'h0
`define ULFS_IDX_IER       3'h1
`define ULFS_IDX_FCR       3'h2
`define ULFS_IDX_LFC       3'h3
`define ULFS_IDX_MOC       3'h4
`define ULFS_IDX_LST       3'h5
`define ULFS_IDX_DLL       3'h0
`define ULFS_IDX_DLM       3'h1
// line format fields
`define ULFS_LF_WLS_LO     0
`define ULFS_LF_WLS_HI     1
`define ULFS_LF_STOP       2
`define ULFS_LF_PEN        3
`define ULFS_LF_EPS        4
`define ULFS_LF_STICK      5
`define ULFS_LF_BREAK      6
`define ULFS_LF_DIVISOR_ACCESS_SELECT       7
// line status fields
`define ULFS_LS_DR         0
`define ULFS_LS_OE         1
`define ULFS_LS_PE         2
`define ULFS_LS_FE         3
`define ULFS_LS_BI         4
`define ULFS_LS_HOLDING_EMPTY_FLAG       5
`define ULFS_LS_TRANSMITTER_IDLE_FLAG       6
`define ULFS_LS_FERR       7
// fifo control fields
`define ULFS_FC_EN         0
`define ULFS_FC_RXCLR      1
`define ULFS_FC_TXCLR      2
`define ULFS_FC_DEEP       5
// reset values
`define ULFS_RST_LFC       8'h03
`define ULFS_RST_MOC       8'h00
`define ULFS_RST_DIV       16'h0001
// fifo geometry
`define ULFS_FIFO_AW       4
`define ULFS_FIFO_DEPTH    5'h10
// rx tag layout: {bi, fe, pe, data[7:0]}
`define ULFS_TAG_PE        8
`define ULFS_TAG_FE        9
`define ULFS_TAG_BI        10
// oversampling
`define ULFS_OVS_LAST      4'hF
`define ULFS_OVS_MID       4'h7
`define ULFS_OVS_HALF_END  4'h7
`endif

// >>> logic/ulfs_uart.v
// Notes on behaviour
// [RL1] one stop; set: 1.5 for 5-bit, else 2
// [RL2] parity enable: insert and check parity
// [RL3] sense set even, clear odd
// [RL4] stick parity: constant, inverse of sense
// [RL5] break bit forces serial output low only
// [RL6] divisor access bit redirects shared locations
// [RL7] receive ready until all data read
// [RL8] overrun on overwrite, clear on status read
// [RL9] fifo overrun: full, shifted char dropped
// [RL10] parity error tagged, shown at head
// [RL11] framing error tagged, shown at head
// [RL12] framing error: stop taken as start
// [RL13] break when low over a character
// [RL14] one zero char; two high samples resume
// [RL15] holding empty set on move, clear on write
// [RL16] transmitter idle when holding and shift empty
// [RL17] fifo error summary while errors queued
// [RL18] four error sources feed line status interrupt
// [RL19] software should not write line status
// [RL20] modem bits set drive outputs low
// [RL21] two bits select five to eight data bits
// [RL22] receiver checks only first stop bit
// [RL23] parity over configured data bits only
// [RL24] error tags travel with fifo data
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`include "ulfs_map.vh"
module ulfs_uart (
   input  wire        CLOCK,      // 250 MHz clock
   input  wire        RST,        // sync reset, active high
   input  wire        WB_CYC_I,   // wishbone cycle
   input  wire        WB_STB_I,   // wishbone strobe
   input  wire        WB_WE_I,    // wishbone write
   input  wire [3:0]  WB_SEL_I,   // byte select
   input  wire [4:0]  WB_ADR_I,   // byte address
   input  wire [31:0] WB_DAT_I,   // write data
   output reg  [31:0] WB_DAT_O,   // read data
   output reg         WB_ACK_O,   // acknowledge
   input  wire        SERIAL_INPUT,  // serial data in
   output reg         SERIAL_OUTPUT, // serial data out
   output reg         DTR_N,      // data terminal ready, low active
   output reg         RTS_N,      // request to send, low active
   output reg         GEN_OUT_A_N, // general output a, low active
   output reg         GEN_OUT_B_N, // general output b, low active
   output wire        LINE_STATUS_EVENT // receiver line status condition
);
   reg  [7:0]  lfc_q;
   reg  [7:0]  moc_q;
   reg  [7:0]  ier_q;
   reg  [15:0] div_q;
   reg         fifo_en_q;
   reg         deep_q;
   reg  [15:0] bcnt_q;
   reg         tick_q;
   reg         sin_m_q;
   reg         sin_s_q;
   // rx fifo and holding buffer share this store; depth 1 outside fifo mode
   reg  [10:0] rxm [0:15];
   reg  [3:0]  rwp_q;
   reg  [3:0]  rrp_q;
   reg  [4:0]  rcnt_q;
   reg  [7:0]  txm [0:15];
   reg  [3:0]  twp_q;
   reg  [3:0]  trp_q;
   reg  [4:0]  tcnt_q;
   reg         oe_q;
   reg         pe_q;
   reg         fe_q;
   reg         bi_q;
   reg         holding_empty_flag_q;
   // transmitter
   reg  [1:0]  tst_q;
   reg  [3:0]  tovs_q;
   reg  [3:0]  tbit_q;
   reg  [7:0]  tsh_q;
   reg         tpar_q;
   reg         tout_q;
   reg         tbusy_q;
   reg  [1:0]  tstop_q;
   // receiver
   reg  [2:0]  rst_q;
   reg  [3:0]  rovs_q;
   reg  [3:0]  rbit_q;
   reg  [7:0]  rsh_q;
   reg         rpar_q;
   reg         rzero_q;
   reg  [1:0]  rhigh_q;

   localparam TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h2, TX_STOP = 2'h3;
   localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3,
              RX_STOP = 3'h4, RX_BRK = 3'h5;

   // data bits per character
   function [3:0] nbits;
      input [1:0] wls;
      begin
         nbits = {2'h0, wls} + 4'h5; // [RL21]
      end
   endfunction

   // parity bit to send or expect
   function parbit;
      input [7:0] d;
      input [7:0] lf;
      reg   [7:0] m;
      begin
         m = 8'h1F;
         case (lf[`ULFS_LF_WLS_HI:`ULFS_LF_WLS_LO])
            2'h1:    m = 8'h3F;
            2'h2:    m = 8'h7F;
            2'h3:    m = 8'hFF;
            default: m = 8'h1F;
         endcase
         if (lf[`ULFS_LF_STICK])
            parbit = ~lf[`ULFS_LF_EPS];            // [RL4]
         else
            parbit = ^(d & m) ^ ~lf[`ULFS_LF_EPS]; // [RL3] [RL23]
      end
   endfunction

   wire       acc    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire [2:0] idx    = WB_ADR_I[4:2];
   wire       divisor_access_select   = lfc_q[`ULFS_LF_DIVISOR_ACCESS_SELECT];
   wire       wr     = acc & WB_WE_I & WB_SEL_I[0];
   wire       rd     = acc & ~WB_WE_I;
   wire       wr_thr = wr & ~divisor_access_select & (idx == `ULFS_IDX_DATA); // [RL6]
   wire       rd_rbr = rd & ~divisor_access_select & (idx == `ULFS_IDX_DATA); // [RL6]
   wire       rd_lst = rd & (idx == `ULFS_IDX_LST);
   wire [4:0] rcap   = fifo_en_q ? `ULFS_FIFO_DEPTH : 5'h01;
   wire [4:0] tcap   = fifo_en_q ? `ULFS_FIFO_DEPTH : 5'h01;
   wire [10:0] rhead = rxm[rrp_q];
   wire       rx_pop = rd_rbr & (rcnt_q != 5'h00);
   wire       tx_push = wr_thr & (tcnt_q != tcap);
   wire       tx_pop;
   reg        rx_push;
   reg  [10:0] rx_word;
   wire       rx_ovr = rx_push & (rcnt_q == rcap) & ~rx_pop; // [RL9]
   reg        fe_now;
   reg        brk_now;
   reg        ferr_sum;
   integer    i;

   always @* begin
      ferr_sum = 1'b0;
      for (i = 0; i < 16; i = i + 1)
         if ((i[4:0] - {1'b0, rrp_q}) % 5'h10 < rcnt_q[4:0] &&
             |rxm[i][`ULFS_TAG_BI:`ULFS_TAG_PE])
            ferr_sum = 1'b1; // [RL17]
   end

   wire [7:0] lst = {fifo_en_q & ferr_sum,                        // [RL17]
                     holding_empty_flag_q & ~tbusy_q,                           // [RL16]
                     holding_empty_flag_q,
                     bi_q, fe_q, pe_q, oe_q,
                     rcnt_q != 5'h00};                            // [RL7]

   assign LINE_STATUS_EVENT = oe_q | pe_q | fe_q | bi_q; // [RL18]

   // bus slave: one-cycle ack, unmapped reads zero and writes ignored
   always @(posedge CLOCK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= acc;
         WB_DAT_O <= 32'h0000_0000;
         if (rd) begin
            case (idx)
               `ULFS_IDX_DATA: WB_DAT_O[7:0] <= divisor_access_select ? div_q[7:0] : rhead[7:0];
               `ULFS_IDX_IER:  WB_DAT_O[7:0] <= divisor_access_select ? div_q[15:8] : ier_q;
               `ULFS_IDX_FCR:  WB_DAT_O[7:0] <= {2'h0, deep_q, 4'h0, fifo_en_q};
               `ULFS_IDX_LFC:  WB_DAT_O[7:0] <= lfc_q;
               `ULFS_IDX_MOC:  WB_DAT_O[7:0] <= moc_q;
               `ULFS_IDX_LST:  WB_DAT_O[7:0] <= lst;
               default:        WB_DAT_O[7:0] <= 8'h00;
            endcase
         end
      end
   end

   // control registers; line status is read only [RL19]
   always @(posedge CLOCK) begin
      if (RST) begin
         lfc_q     <= `ULFS_RST_LFC;
         moc_q     <= `ULFS_RST_MOC;
         ier_q     <= 8'h00;
         div_q     <= `ULFS_RST_DIV;
         fifo_en_q <= 1'b0;
         deep_q    <= 1'b0;
      end else if (wr) begin
         case (idx)
            `ULFS_IDX_DATA: if (divisor_access_select) div_q[7:0] <= WB_DAT_I[7:0];    // [RL6]
            `ULFS_IDX_IER:  if (divisor_access_select) div_q[15:8] <= WB_DAT_I[7:0];   // [RL6]
                            else ier_q <= WB_DAT_I[7:0];
            `ULFS_IDX_FCR: begin
               fifo_en_q <= WB_DAT_I[`ULFS_FC_EN];
               if (divisor_access_select) deep_q <= WB_DAT_I[`ULFS_FC_DEEP];           // [RL6]
            end
            `ULFS_IDX_LFC:  lfc_q <= WB_DAT_I[7:0];
            `ULFS_IDX_MOC:  moc_q <= WB_DAT_I[7:0];
            default: ;
         endcase
      end
   end

   // modem outputs, inverted sense
   always @(posedge CLOCK) begin
      if (RST) begin
         DTR_N       <= 1'b1;
         RTS_N       <= 1'b1;
         GEN_OUT_A_N <= 1'b1;
         GEN_OUT_B_N <= 1'b1;
      end else begin
         DTR_N       <= ~moc_q[0]; // [RL20]
         RTS_N       <= ~moc_q[1]; // [RL20]
         GEN_OUT_A_N <= ~moc_q[2]; // [RL20]
         GEN_OUT_B_N <= ~moc_q[3]; // [RL20]
      end
   end

   // 16x oversampling tick from divisor
   always @(posedge CLOCK) begin
      if (RST || (wr && divisor_access_select && idx <= `ULFS_IDX_IER)) begin
         bcnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (bcnt_q + 16'h0001 >= div_q);
         bcnt_q <= (bcnt_q + 16'h0001 >= div_q) ? 16'h0000 : bcnt_q + 16'h0001;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         sin_m_q <= 1'b1;
         sin_s_q <= 1'b1;
      end else begin
         sin_m_q <= SERIAL_INPUT;
         sin_s_q <= sin_m_q;
      end
   end

   // transmit fifo / holding register
   assign tx_pop = (tst_q == TX_IDLE) & tick_q & (tcnt_q != 5'h00);
   always @(posedge CLOCK) begin
      if (RST || (wr && idx == `ULFS_IDX_FCR && WB_DAT_I[`ULFS_FC_TXCLR])) begin
         twp_q  <= 4'h0;
         trp_q  <= 4'h0;
         tcnt_q <= 5'h00;
         holding_empty_flag_q <= 1'b1;
      end else begin
         if (tx_push) begin
            txm[twp_q] <= WB_DAT_I[7:0];
            twp_q      <= twp_q + 4'h1;
         end
         if (tx_pop)
            trp_q <= trp_q + 4'h1;
         tcnt_q <= tcnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
         if (wr_thr)
            holding_empty_flag_q <= 1'b0;                                   // [RL15]
         else if (tx_pop && tcnt_q == 5'h01)
            holding_empty_flag_q <= 1'b1;                                   // [RL15]
      end
   end

   // transmitter: start, data, optional parity, stop
   always @(posedge CLOCK) begin
      if (RST) begin
         tst_q   <= TX_IDLE;
         tovs_q  <= 4'h0;
         tbit_q  <= 4'h0;
         tsh_q   <= 8'h00;
         tpar_q  <= 1'b0;
         tout_q  <= 1'b1;
         tbusy_q <= 1'b0;
         tstop_q <= 2'h0;
      end else if (tick_q) begin
         tovs_q <= tovs_q + 4'h1;
         case (tst_q)
            TX_IDLE: if (tx_pop) begin
               tsh_q   <= txm[trp_q];
               tpar_q  <= parbit(txm[trp_q], lfc_q);
               tst_q   <= TX_START;
               tovs_q  <= 4'h0;
               tout_q  <= 1'b0;
               tbusy_q <= 1'b1;
            end
            TX_START: if (tovs_q == `ULFS_OVS_LAST) begin
               tst_q  <= TX_DATA;
               tbit_q <= 4'h0;
               tout_q <= tsh_q[0];
            end
            TX_DATA: if (tovs_q == `ULFS_OVS_LAST) begin
               // 4'hF marks the parity slot, so it must not count as a data bit
               if (tbit_q != 4'hF && tbit_q + 4'h1 < nbits(lfc_q[1:0])) begin
                  tbit_q <= tbit_q + 4'h1;
                  tsh_q  <= {1'b0, tsh_q[7:1]};
                  tout_q <= tsh_q[1];
               end else if (lfc_q[`ULFS_LF_PEN] && tbit_q != 4'hF) begin
                  tbit_q <= 4'hF;
                  tout_q <= tpar_q;                          // [RL2]
               end else begin
                  tst_q   <= TX_STOP;
                  tout_q  <= 1'b1;
                  tstop_q <= lfc_q[`ULFS_LF_STOP] ?
                             ((lfc_q[1:0] == 2'h0) ? 2'h1 : 2'h2) : 2'h0; // [RL1]
               end
            end
            TX_STOP: begin
               if (tstop_q == 2'h3) begin
                  if (tovs_q == `ULFS_OVS_HALF_END) begin
                     tst_q   <= TX_IDLE;
                     tbusy_q <= 1'b0;
                  end
               end else if (tovs_q == `ULFS_OVS_LAST) begin
                  case (tstop_q)
                     2'h1:    tstop_q <= 2'h3; // half stop bit still to go
                     2'h2:    tstop_q <= 2'h0; // second full stop bit
                     default: begin
                        tst_q   <= TX_IDLE;
                        tbusy_q <= 1'b0;
                     end
                  endcase
               end
            end
            default: tst_q <= TX_IDLE;
         endcase
      end
   end

   always @(posedge CLOCK) begin
      if (RST)
         SERIAL_OUTPUT <= 1'b1;
      else
         SERIAL_OUTPUT <= tout_q & ~lfc_q[`ULFS_LF_BREAK]; // [RL5]
   end

   // stop-bit decode: finished character and its error tags
   always @* begin
      rx_push = 1'b0;
      rx_word = 11'h000;
      fe_now  = 1'b0;
      brk_now = 1'b0;
      if (!RST && tick_q && rst_q == RX_STOP && rovs_q == `ULFS_OVS_MID) begin
         rx_word[7:0] = rsh_q >> (4'h8 - nbits(lfc_q[1:0]));
         brk_now = rzero_q & ~sin_s_q;                    // [RL13]
         fe_now  = ~sin_s_q;                              // [RL11]
         rx_word[`ULFS_TAG_PE] = lfc_q[`ULFS_LF_PEN] & ~brk_now &
                                 (rpar_q != parbit(rx_word[7:0], lfc_q)); // [RL10]
         rx_word[`ULFS_TAG_FE] = fe_now;
         rx_word[`ULFS_TAG_BI] = brk_now;
         if (brk_now) rx_word[7:0] = 8'h00;               // [RL14]
         rx_push = 1'b1;
      end
   end

   // receiver: sample mid-bit, first stop only
   always @(posedge CLOCK) begin
      if (RST) begin
         rst_q   <= RX_IDLE;
         rovs_q  <= 4'h0;
         rbit_q  <= 4'h0;
         rsh_q   <= 8'h00;
         rpar_q  <= 1'b0;
         rzero_q <= 1'b1;
         rhigh_q <= 2'h0;
      end else if (tick_q) begin
         rovs_q <= rovs_q + 4'h1;
         case (rst_q)
            RX_IDLE: if (!sin_s_q) begin
               rst_q  <= RX_START;
               rovs_q <= 4'h0;
            end
            RX_START: if (rovs_q == `ULFS_OVS_MID) begin
               if (sin_s_q) rst_q <= RX_IDLE; // false start
               else begin
                  rst_q   <= RX_DATA;
                  rovs_q  <= `ULFS_OVS_MID + 4'h1;
                  rbit_q  <= 4'h0;
                  rzero_q <= 1'b1;
               end
            end
            RX_DATA: if (rovs_q == `ULFS_OVS_MID) begin
               rsh_q   <= {sin_s_q, rsh_q[7:1]};
               rzero_q <= rzero_q & ~sin_s_q;
               if (rbit_q + 4'h1 == nbits(lfc_q[1:0]))
                  rst_q <= lfc_q[`ULFS_LF_PEN] ? RX_PAR : RX_STOP; // [RL2]
               rbit_q <= rbit_q + 4'h1;
            end
            RX_PAR: if (rovs_q == `ULFS_OVS_MID) begin
               rpar_q  <= sin_s_q;
               rzero_q <= rzero_q & ~sin_s_q;
               rst_q   <= RX_STOP;
            end
            RX_STOP: if (rovs_q == `ULFS_OVS_MID) begin           // [RL22]
               rhigh_q <= 2'h0;
               if (brk_now)
                  rst_q <= RX_BRK;
               else if (fe_now) begin
                  // stop sample was the first look at the new start bit
                  rst_q  <= RX_START;                           // [RL12]
                  rovs_q <= `ULFS_OVS_MID;
               end else
                  rst_q <= RX_IDLE;
            end
            RX_BRK: begin
               if (sin_s_q && rhigh_q != 2'h2) rhigh_q <= rhigh_q + 2'h1;
               else if (!sin_s_q) rhigh_q <= 2'h0;
               if (rhigh_q == 2'h2) rst_q <= RX_IDLE;            // [RL14]
            end
            default: rst_q <= RX_IDLE;
         endcase
      end
   end

   // rx fifo with per-entry tags; latched status flags
   always @(posedge CLOCK) begin
      if (RST || (wr && idx == `ULFS_IDX_FCR && WB_DAT_I[`ULFS_FC_RXCLR])) begin
         rwp_q  <= 4'h0;
         rrp_q  <= 4'h0;
         rcnt_q <= 5'h00;
         oe_q   <= 1'b0;
         pe_q   <= 1'b0;
         fe_q   <= 1'b0;
         bi_q   <= 1'b0;
      end else begin
         if (rx_push && !rx_ovr) begin
            rxm[fifo_en_q ? rwp_q : rrp_q] <= rx_word;           // [RL24]
            if (fifo_en_q) rwp_q <= rwp_q + 4'h1;
         end
         if (rx_pop && fifo_en_q) rrp_q <= rrp_q + 4'h1;
         if (!fifo_en_q) rwp_q <= rrp_q;
         rcnt_q <= rcnt_q + {4'h0, rx_push & ~rx_ovr} - {4'h0, rx_pop}; // [RL7]
         // overwrite of unread holding byte outside fifo mode
         if (!fifo_en_q && rx_push && rcnt_q != 5'h00 && !rx_pop) begin
            rxm[rrp_q] <= rx_word;                               // [RL8]
            rcnt_q     <= rcnt_q;
         end
         // set wins over clear on the same cycle
         oe_q <= (oe_q & ~rd_lst) | (rx_push & (rcnt_q == rcap) & ~rx_pop); // [RL8] [RL9]
         if (fifo_en_q) begin
            pe_q <= (pe_q & ~rd_lst) | (rx_pop && rcnt_q > 5'h01 ?
                    rxm[rrp_q + 4'h1][`ULFS_TAG_PE] :
                    (rcnt_q == 5'h00 && rx_push & rx_word[`ULFS_TAG_PE])); // [RL10]
            fe_q <= (fe_q & ~rd_lst) | (rx_pop && rcnt_q > 5'h01 ?
                    rxm[rrp_q + 4'h1][`ULFS_TAG_FE] :
                    (rcnt_q == 5'h00 && rx_push & rx_word[`ULFS_TAG_FE])); // [RL11]
            bi_q <= (bi_q & ~rd_lst) | (rx_pop && rcnt_q > 5'h01 ?
                    rxm[rrp_q + 4'h1][`ULFS_TAG_BI] :
                    (rcnt_q == 5'h00 && rx_push & rx_word[`ULFS_TAG_BI])); // [RL13]
         end else begin
            pe_q <= (pe_q & ~rd_lst) | (rx_push & rx_word[`ULFS_TAG_PE]); // [RL10]
            fe_q <= (fe_q & ~rd_lst) | (rx_push & rx_word[`ULFS_TAG_FE]); // [RL11]
            bi_q <= (bi_q & ~rd_lst) | (rx_push & rx_word[`ULFS_TAG_BI]); // [RL13]
         end
      end
   end
endmodule

// >>> dv/ulfs_checker.sv
module ulfs_checker (
   input wire        CLOCK,            // clock
   input wire        RST,              // reset
   input wire        WB_CYC_I,         // cycle
   input wire        WB_STB_I,         // strobe
   input wire        WB_WE_I,          // write
   input wire [3:0]  WB_SEL_I,         // lanes
   input wire [4:0]  WB_ADR_I,         // address
   input wire [31:0] WB_DAT_I,         // wdata
   input wire [31:0] WB_DAT_O,         // rdata
   input wire        WB_ACK_O,         // ack
   input wire        SERIAL_INPUT,     // rx line
   input wire        SERIAL_OUTPUT,    // tx line
   input wire        DTR_N,            // modem out
   input wire        RTS_N,            // modem out
   input wire        GEN_OUT_A_N,      // modem out
   input wire        GEN_OUT_B_N,      // modem out
   input wire        LINE_STATUS_EVENT // error event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   logic       take;
   logic [2:0] idx;
   logic       ls_rd_q;
   logic       fifo_q;
   logic [7:0] moc_q;
   logic [7:0] lfc_q;
   logic [1:0] age_q;
   assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign idx = WB_ADR_I[4:2];
   // shadow of written control bits, age counts cycles since last write
   always @(posedge CLOCK) begin
      if (RST) begin
         ls_rd_q <= 1'b0;
         fifo_q <= 1'b0;
         moc_q <= 8'h00;
         lfc_q <= 8'h03;
         age_q <= 2'h0;
      end else begin
         ls_rd_q <= take & ~WB_WE_I & (idx == 3'h5);
         if (take & WB_WE_I & WB_SEL_I[0]) begin
            age_q <= 2'h0;
            if (idx == 3'h4) moc_q <= WB_DAT_I[7:0];
            if (idx == 3'h3) lfc_q <= WB_DAT_I[7:0];
            if (idx == 3'h2) fifo_q <= WB_DAT_I[0];
         end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
         end
      end
   end
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held over one cycle");
   a_ack_answer: assert property (take |=> WB_ACK_O)
      else $error("request not answered next cycle");
   a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I & WB_STB_I))
      else $error("ack without request");
   a_modem_pins: assert property ((age_q == 2'h3) |->
      ({GEN_OUT_B_N, GEN_OUT_A_N, RTS_N, DTR_N} == ~moc_q[3:0]))
      else $error("modem outputs differ from control bits");
   a_break_low: assert property ((age_q == 2'h3 && lfc_q[6]) |-> !SERIAL_OUTPUT)
      else $error("serial output high during break");
   a_err_summary: assert property ((ls_rd_q && WB_ACK_O && !fifo_q) |-> !WB_DAT_O[7])
      else $error("error summary set outside fifo mode");
   a_event_flags: assert property ((ls_rd_q && WB_ACK_O) |->
      ($past(LINE_STATUS_EVENT) == (|WB_DAT_O[4:1])))
      else $error("status event differs from error flags");
   a_idle_holding: assert property ((ls_rd_q && WB_ACK_O && WB_DAT_O[6]) |-> WB_DAT_O[5])
      else $error("transmitter idle while holding full");
   c_error_read: cover property (ls_rd_q && WB_ACK_O && WB_DAT_O[4]);
   c_event: cover property (LINE_STATUS_EVENT);
   c_break_out: cover property (age_q == 2'h3 && lfc_q[6]);
endmodule

// >>> dv/ulfs_peer.sv
module ulfs_peer (
   input  wire logic clk,      // bench clock
   input  wire logic line_in,  // from design
   output logic      line_out  // to design
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line_out = 1'b1;
   task automatic hold(input logic v, input int n);
      line_out <= v;
      repeat (n) @(posedge clk);
   endtask
   // 8 data bits plus parity, lsb first; strt low continues a previous frame
   task automatic send(input logic [7:0] d, input logic p, input logic stp,
                       input logic strt, input int idle);
      int i;
      if (strt) hold(1'b0, 16);
      for (i = 0; i < 8; i++) hold(d[i], 16);
      hold(p, 16);
      hold(stp, 16);
      if (idle > 0) hold(1'b1, idle);
   endtask
   // hb: half bits from this start edge to the next one
   task automatic grab(input int nb, input logic hp, output logic [7:0] d,
                       output logic p, output logic [7:0] hb);
      int i;
      int c;
      d = 8'h00;
      p = 1'b0;
      while (line_in !== 1'b0) @(posedge clk);
      repeat (8) @(posedge clk);
      for (i = 0; i < nb; i++) begin
         repeat (16) @(posedge clk);
         d[i] = line_in;
      end
      if (hp) begin
         repeat (16) @(posedge clk);
         p = line_in;
      end
      repeat (16) @(posedge clk);
      c = 24 + 16 * (nb + int'(hp));
      while (line_in !== 1'b0 && c < 400) begin
         @(posedge clk);
         c++;
      end
      hb = 8'((c + 4) / 8);
   endtask
endmodule

// >>> dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  sel = 4'hF;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack, serial_input, serial_output, dtr_n, rts_n, oa_n, ob_n, ev;
   int          errors = 0;
   int          n_tests = 0;
   int          k, nb, sh;
   logic [7:0]  md, gd, gh, q;
   logic        gp, ep, hp;
   logic [7:0]  fmt [6] = '{8'h00, 8'h04, 8'h0D, 8'h1A, 8'h3B, 8'h2F};
   always #2 clk = ~clk;
   ulfs_uart u_dut (
      .CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .SERIAL_INPUT(serial_input), .SERIAL_OUTPUT(serial_output), .DTR_N(dtr_n), .RTS_N(rts_n),
      .GEN_OUT_A_N(oa_n), .GEN_OUT_B_N(ob_n), .LINE_STATUS_EVENT(ev));
   ulfs_peer u_peer (.clk(clk), .line_in(serial_output), .line_out(serial_input));
   task automatic wrap_up;
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d,
                      output logic [7:0] v);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (ack !== 1'b1) errors++;
      v = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [2:0] i, input logic [7:0] d);
      logic [7:0] v;
      bus(1'b1, i, d, v);
   endtask
   task automatic chk(input logic [2:0] i, input logic [7:0] e);
      logic [7:0] v;
      bus(1'b0, i, 8'h00, v);
      cmp(v, e);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(3'h3, 8'h03);
      chk(3'h4, 8'h00);
      chk(3'h5, 8'h60);
      chk(3'h6, 8'h00);
      wr(3'h5, 8'hFF);
      chk(3'h5, 8'h60);
      for (k = 0; k < 4; k++) begin
         wr(3'h4, 8'(1 << k));
         repeat (2) @(posedge clk);
         cmp({4'h0, ob_n, oa_n, rts_n, dtr_n}, 8'(~(1 << k) & 15));
      end
      wr(3'h3, 8'h43);
      repeat (3) @(posedge clk);
      cmp({7'h00, serial_output}, 8'h00);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h00);
      chk(3'h0, 8'h01);
      chk(3'h3, 8'h83);
      wr(3'h3, 8'h03);
      cmp({7'h00, serial_output}, 8'h01);
      chk(3'h5, 8'h60);
      for (k = 0; k < 6; k++) begin
         nb = 5 + fmt[k][1:0];
         hp = fmt[k][3];
         md = 8'((1 << nb) - 1) & 8'hB5;
         ep = fmt[k][5] ? ~fmt[k][4] : ~(fmt[k][4] ^ (^md));
         sh = !fmt[k][2] ? 2 : (nb == 5 ? 3 : 4);
         wr(3'h3, fmt[k]);
         fork
            u_peer.grab(nb, hp, gd, gp, gh);
            begin
               wr(3'h0, 8'hB5);
               repeat (4) @(posedge clk);
               wr(3'h0, 8'hB5);
               chk(3'h5, 8'h00);
            end
         join
         cmp(gd, md);
         cmp({7'h00, gp}, {7'h00, ep & hp});
         cmp(gh, 8'(2 * (1 + nb + hp) + sh));
         u_peer.grab(nb, hp, gd, gp, gh);
         cmp(gd, md);
         chk(3'h5, 8'h60);
      end
      wr(3'h3, 8'h1B);
      u_peer.send(8'hA5, ^8'hA5, 1'b1, 1'b1, 32);
      chk(3'h5, 8'h61);
      chk(3'h0, 8'hA5);
      chk(3'h5, 8'h60);
      u_peer.send(8'h3C, ~^8'h3C, 1'b1, 1'b1, 32);
      chk(3'h5, 8'h65);
      chk(3'h5, 8'h61);
      chk(3'h0, 8'h3C);
      u_peer.send(8'h5A, ^8'h5A, 1'b0, 1'b1, 0);
      u_peer.send(8'hC3, ^8'hC3, 1'b1, 1'b0, 32);
      chk(3'h5, 8'h6B);
      chk(3'h0, 8'hC3);
      chk(3'h5, 8'h60);
      u_peer.hold(1'b0, 224);
      u_peer.hold(1'b1, 64);
      bus(1'b0, 3'h5, 8'h00, q);
      cmp(q & 8'h11, 8'h11);
      chk(3'h0, 8'h00);
      chk(3'h5, 8'h60);
      u_peer.send(8'h81, ^8'h81, 1'b1, 1'b1, 32);
      chk(3'h0, 8'h81);
      wr(3'h2, 8'h07);
      for (k = 0; k < 17; k++) u_peer.send(8'(k), ^8'(k), 1'b1, 1'b1, 0);
      chk(3'h5, 8'h63);
      for (k = 0; k < 16; k++) chk(3'h0, 8'(k));
      chk(3'h5, 8'h60);
      u_peer.send(8'h11, ^8'h11, 1'b1, 1'b1, 0);
      u_peer.send(8'h22, ~^8'h22, 1'b1, 1'b1, 32);
      chk(3'h5, 8'hE1);
      chk(3'h0, 8'h11);
      chk(3'h5, 8'hE5);
      chk(3'h0, 8'h22);
      bus(1'b0, 3'h5, 8'h00, q);
      chk(3'h5, 8'h60);
      wrap_up();
   end
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      wrap_up();
   end
endmodule
bind ulfs_uart ulfs_checker u_chk (
   .CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SERIAL_INPUT(SERIAL_INPUT),
   .SERIAL_OUTPUT(SERIAL_OUTPUT), .DTR_N(DTR_N), .RTS_N(RTS_N),
   .GEN_OUT_A_N(GEN_OUT_A_N), .GEN_OUT_B_N(GEN_OUT_B_N),
   .LINE_STATUS_EVENT(LINE_STATUS_EVENT));
